// File: tdmps_serial_port.sv
// tdm pcm serial port: pulse format detection, framing, loopback streams, wishbone regs
`include "tdmps_params.svh"

// Summary of operation
// R1 - outputs drive only when gate pin and control bit 6 both high
// R2 - send-out and receive-out carry 32 timeslots per frame at 2.048 Mb/s
// R3 - send-in and receive-in are sampled as 32 timeslots per frame
// R4 - frame pulse format recognised automatically from its idle level
// R5 - external 4.096 MHz bit clock shifts all four streams
// R6 - core clock asynchronous to framing; link signals pass two flip-flops
// R7 - master frequency select pin is observed and reported in status
// R8 - registers carry 8-bit data on the host bus
// R9 - eleven address bits select the internal register
// R10 - reset presets all control and status to defaults, drive bit cleared
// R11 - frame is 32 slots of 8 bits, two bit clocks per bit
module tdmps_serial_port
  import tdmps_pkg::*;
(
  // system
  input  wire logic        clk,
  input  wire logic        reset,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [12:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // link pins
  input  wire logic        serial_bit_clock_in,
  input  wire logic        frame_pulse_in,
  input  wire logic        send_in,
  input  wire logic        receive_in,
  input  wire logic        output_drive_gate,
  input  wire logic        freq_select,
  // serial outputs, enables low while driving
  output logic             send_out,
  output logic             send_out_oe_n,
  output logic             receive_out,
  output logic             receive_out_oe_n
);

  // ----------------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------------
  localparam int NSYNC = 6;
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  logic             bclk_d;
  logic             bclk_s;
  logic             fp_s;
  logic             sin_s;
  logic             rin_s;
  logic             gate_s;
  logic             fsel_s;

  // every link pin passes two flops before use; first stage read by second only
  always_ff @(posedge clk) begin
    if (reset) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {freq_select, output_drive_gate, receive_in, send_in, frame_pulse_in,
                serial_bit_clock_in}; // R6
      sync2 <= sync1; // R6
    end
  end

  assign bclk_s = sync2[0];
  assign fp_s   = sync2[1];
  assign sin_s  = sync2[2];
  assign rin_s  = sync2[3];
  assign gate_s = sync2[4];
  assign fsel_s = sync2[5]; // R7

  // ----------------------------------------------------------------------------
  // bit clock edge detection
  // ----------------------------------------------------------------------------
  logic bit_edge;

  // edge taken from the second stage, never from the first
  always_ff @(posedge clk) begin
    if (reset) begin
      bclk_d <= 1'b0;
    end else begin
      bclk_d <= bclk_s;
    end
  end

  assign bit_edge = bclk_s & ~bclk_d; // R5

  // ----------------------------------------------------------------------------
  // frame pulse format recognition
  // ----------------------------------------------------------------------------
  tdmps_fmt_t fmt;
  logic [2:0] run;
  logic       fp_prev;
  logic       frame_start;
  logic       idle_level;
  assign idle_level  = (fmt == TDMPS_FMT_LOW_PULSE);
  // a pulse is any departure from the settled idle level
  assign frame_start = bit_edge && (fmt != TDMPS_FMT_NONE) &&
                       (fp_s != idle_level) && (fp_prev == idle_level); // R4

  // idle level is the one that holds for several bit clocks; no setting needed
  always_ff @(posedge clk) begin
    if (reset) begin
      fmt     <= TDMPS_FMT_NONE;
      run     <= 3'h0;
      fp_prev <= 1'b0;
    end else if (bit_edge) begin
      fp_prev <= fp_s;
      if (fp_s != fp_prev) begin
        run <= 3'h0;
      end else if (run != `TDMPS_IDLE_RUN) begin
        run <= run + 3'h1;
      end else begin
        fmt <= fp_s ? TDMPS_FMT_LOW_PULSE : TDMPS_FMT_HIGH_PULSE; // R4
      end
    end
  end

  // ----------------------------------------------------------------------------
  // frame counter: slot in [8:4], bit in [3:1], half bit in [0]
  // ----------------------------------------------------------------------------
  logic [8:0] cnt;
  logic [4:0] slot;
  logic [7:0] frames;
  assign slot = cnt[8:4];

  // counter realigns on every recognised pulse, free-runs in between
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt    <= 9'h000;
      frames <= 8'h00;
    end else if (frame_start) begin
      cnt    <= 9'h000; // R11
      frames <= frames + 8'h01;
    end else if (bit_edge) begin
      cnt <= (cnt == `TDMPS_CNT_LAST) ? 9'h000 : cnt + 9'h001; // R2
    end
  end

  // ----------------------------------------------------------------------------
  // receive side: shift both inputs, store each slot
  // ----------------------------------------------------------------------------
  logic [7:0]  sin_sh;
  logic [7:0]  rin_sh;
  logic        wr_en;
  logic [15:0] rd_data;
  logic [4:0]  rd_addr;
  // cnt still holds the previous position at an edge: even means second clock of a bit
  always_ff @(posedge clk) begin
    if (reset) begin
      sin_sh <= 8'h00;
      rin_sh <= 8'h00;
    end else if (bit_edge && !cnt[0]) begin
      sin_sh <= {sin_sh[6:0], sin_s}; // R3
      rin_sh <= {rin_sh[6:0], rin_s}; // R3
    end
  end

  // eighth sample is taken as cnt moves 14 to 15, so slot still names its own slot
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_en <= 1'b0;
    end else begin
      wr_en <= bit_edge && !frame_start && (cnt[3:0] == 4'hE); // R3
    end
  end

  assign rd_addr = slot + 5'h01;

  tdmps_slot_mem #(
    .WIDTH (16),
    .DEPTH (`TDMPS_SLOTS),
    .AW    (5)
  ) u_mem (
    .clk     (clk),
    .wr_en   (wr_en),
    .wr_addr (slot),
    .wr_data ({sin_sh, rin_sh}),
    .rd_addr (rd_addr),
    .rd_data (rd_data)
  );

  // ----------------------------------------------------------------------------
  // transmit side: one frame loopback, msb first, bit held two bit clocks
  // ----------------------------------------------------------------------------
  logic [7:0] sout_sh;
  logic [7:0] rout_sh;

  // reload at slot start with next slot's byte read during the previous slot
  always_ff @(posedge clk) begin
    if (reset) begin
      sout_sh <= 8'h00;
      rout_sh <= 8'h00;
    end else if (bit_edge && cnt[3:0] == 4'hF) begin
      sout_sh <= rd_data[15:8]; // R11
      rout_sh <= rd_data[7:0];
    end else if (bit_edge && cnt[0]) begin
      sout_sh <= {sout_sh[6:0], 1'b0}; // R2
      rout_sh <= {rout_sh[6:0], 1'b0};
    end
  end

  // data pins come from flops; level follows shift msb
  always_ff @(posedge clk) begin
    if (reset) begin
      send_out    <= 1'b0;
      receive_out <= 1'b0;
    end else begin
      send_out    <= sout_sh[7]; // R2
      receive_out <= rout_sh[7];
    end
  end

  // ----------------------------------------------------------------------------
  // control register and output gating
  // ----------------------------------------------------------------------------
  logic [7:0]  ctrl;
  logic [10:0] idx;
  logic        access;
  logic        driving;

  assign idx    = wb_adr_i[12:2]; // R9
  assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // only the low byte lane holds register data
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl <= `TDMPS_CTRL_RESET; // R10
    end else if (access && wb_we_i && wb_sel_i[0] && idx == `TDMPS_IDX_CTRL) begin
      ctrl <= wb_dat_i[7:0]; // R8
    end
  end

  assign driving = gate_s && ctrl[`TDMPS_CTRL_DRIVE_BIT];

  // both enables follow the and of pin and bit; high means released
  always_ff @(posedge clk) begin
    if (reset) begin
      send_out_oe_n    <= 1'b1;
      receive_out_oe_n <= 1'b1;
    end else begin
      send_out_oe_n    <= !driving; // R1
      receive_out_oe_n <= !driving; // R1
    end
  end

  // ----------------------------------------------------------------------------
  // wishbone slave: one wait state, unmapped reads return zero
  // ----------------------------------------------------------------------------
  logic [7:0] status;
  logic [7:0] next_rdata;

  assign status = {3'h0, driving, gate_s, fsel_s, fmt == TDMPS_FMT_HIGH_PULSE,
                   fmt != TDMPS_FMT_NONE}; // R7

  // decode of eleven address bits; unused codes read zero
  always_comb begin
    case (idx)
      `TDMPS_IDX_CTRL:   next_rdata = ctrl;
      `TDMPS_IDX_STATUS: next_rdata = status;
      `TDMPS_IDX_FRAMES: next_rdata = frames;
      default:           next_rdata = 8'h00;
    endcase
  end

  // ack for exactly one cycle, data captured alongside it
  always_ff @(posedge clk) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= access; // R8
      if (access && !wb_we_i) begin
        wb_dat_o <= {24'h000000, next_rdata}; // R8
      end
    end
  end

  // ----------------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------------
  property p_drive_gate;
    @(posedge clk) disable iff (reset)
      (gate_s && ctrl[`TDMPS_CTRL_DRIVE_BIT]) |=> (!send_out_oe_n && !receive_out_oe_n);
  endproperty
  a_drive_gate: assert property (p_drive_gate) else $error("outputs not driven"); // R1
  property p_release;
    @(posedge clk) disable iff (reset)
      (!gate_s || !ctrl[`TDMPS_CTRL_DRIVE_BIT]) |=> (send_out_oe_n && receive_out_oe_n);
  endproperty
  a_release: assert property (p_release) else $error("outputs driven while gated"); // R1
  property p_wrap;
    @(posedge clk) disable iff (reset)
      (bit_edge && !frame_start && cnt == `TDMPS_CNT_LAST) |=> (cnt == 9'h000);
  endproperty
  a_wrap: assert property (p_wrap) else $error("frame counter did not wrap"); // R2
  property p_slot_write;
    @(posedge clk) disable iff (reset)
      (bit_edge && !frame_start && cnt[3:0] == 4'hE) |=> wr_en;
  endproperty
  a_slot_write: assert property (p_slot_write) else $error("slot not stored"); // R3
  property p_align;
    @(posedge clk) disable iff (reset)
      frame_start |=> (cnt == 9'h000) ##1 (cnt == 9'h000);
  endproperty
  a_align: assert property (p_align) else $error("frame not realigned"); // R4
  property p_edge_single;
    @(posedge clk) disable iff (reset)
      bit_edge |=> !bit_edge;
  endproperty
  a_edge_single: assert property (p_edge_single) else $error("edge lasted two cycles"); // R5
  property p_ack_once;
    @(posedge clk) disable iff (reset)
      access |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack not a single pulse"); // R8
  property p_ctrl_read;
    @(posedge clk) disable iff (reset)
      (access && !wb_we_i && idx == 11'h000) |=> (wb_dat_o == {24'h000000, $past(ctrl)});
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control read mismatch"); // R9
  property p_reset_ctrl;
    @(posedge clk) reset |=> (ctrl == 8'h00 && send_out_oe_n && fmt == TDMPS_FMT_NONE);
  endproperty
  a_reset_ctrl: assert property (p_reset_ctrl) else $error("reset defaults wrong"); // R10
  property p_bit_hold;
    @(posedge clk) disable iff (reset)
      (bit_edge && !cnt[0] && !frame_start) |=> $stable(sout_sh);
  endproperty
  a_bit_hold: assert property (p_bit_hold) else $error("bit held under two clocks"); // R11

endmodule : tdmps_serial_port

// File: tdmps_params.svh
// constants for the tdm pcm serial port: offsets, fields, reset values, timing
`ifndef TDMPS_PARAMS_SVH
`define TDMPS_PARAMS_SVH

// ----------------------------------------------------------------------------
// register map (word index = wishbone byte address bits 12:2)
// ----------------------------------------------------------------------------
`define TDMPS_IDX_CTRL       11'h000
`define TDMPS_IDX_STATUS     11'h001
`define TDMPS_IDX_FRAMES     11'h002
`define TDMPS_CTRL_RESET     8'h00
`define TDMPS_CTRL_DRIVE_BIT 6

// status fields
`define TDMPS_ST_LOCKED      0
`define TDMPS_ST_HIGH_PULSE  1
`define TDMPS_ST_FSEL        2
`define TDMPS_ST_GATE_PIN    3
`define TDMPS_ST_DRIVING     4

// ----------------------------------------------------------------------------
// frame geometry and timing
// ----------------------------------------------------------------------------
`define TDMPS_SLOTS          32
`define TDMPS_BITS_PER_SLOT  8
`define TDMPS_CLKS_PER_BIT   2
`define TDMPS_CNT_LAST       9'h1FF
`define TDMPS_IDLE_RUN       3'h4
`define TDMPS_BIT_CLK_KHZ    4096
`define TDMPS_SYS_CLK_KHZ    125000

`endif

// File: tdmps_pkg.sv
// types shared by the tdm pcm serial port
package tdmps_pkg;

  // ----------------------------------------------------------------------------
  // frame pulse format as recognised from the idle level of the pulse line
  // ----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    TDMPS_FMT_NONE,
    TDMPS_FMT_LOW_PULSE,
    TDMPS_FMT_HIGH_PULSE
  } tdmps_fmt_t;

endpackage : tdmps_pkg

// File: tdmps_slot_mem.sv
// per-timeslot sample store, one write and one registered read port
module tdmps_slot_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  // clock
  input  wire logic             clk,
  // write side
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // read side
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  // storage has no reset: contents are don't-care until first frame written
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // registered read port
  always_ff @(posedge clk) begin
    rd_data <= mem[rd_addr];
  end

endmodule : tdmps_slot_mem

// File: tdmps_framer_model.sv
// backplane framer model: bit clock, frame pulses, input streams, output capture
module tdmps_framer_model (
  // control from the bench
  input  wire logic run,
  input  wire logic high_pulse,
  // link towards the port
  output logic      serial_bit_clock_in,
  output logic      frame_pulse_in,
  output logic      send_in,
  output logic      receive_in,
  // streams coming back
  input  wire logic send_out,
  input  wire logic send_out_oe_n,
  input  wire logic receive_out,
  input  wire logic receive_out_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;

  event       frame_ev;
  int         pos = 0;
  int         frame = 0;
  logic [7:0] tx_s[32], tx_r[32], old_s[32], old_r[32];
  logic [7:0] rx_s[32], rx_r[32], got_s[32], got_r[32], exp_s[32], exp_r[32];
  logic       last_s = 1'b0;
  logic       last_r = 1'b0;

  // idle line levels until the first frame starts
  initial begin
    serial_bit_clock_in = 1'b0;
    frame_pulse_in = 1'b1;
    send_in = 1'b0;
    receive_in = 1'b0;
    foreach (tx_s[i]) begin
      tx_s[i] = 8'h00;
      tx_r[i] = 8'h00;
    end
  end

  // the bit clock stands still until the bench lets traffic flow
  always #32 if (run) serial_bit_clock_in = ~serial_bit_clock_in;

  // launch on the falling edge so every level is settled at the rising edge
  always @(negedge serial_bit_clock_in) begin
    if (pos == 0) begin
      got_s = rx_s;
      got_r = rx_r;
      exp_s = old_s;
      exp_r = old_r;
      old_s = tx_s;
      old_r = tx_r;
      frame++;
      foreach (tx_s[i]) begin
        tx_s[i] = 8'(frame * 29 + i * 5);
        tx_r[i] = ~tx_s[i];
      end
      -> frame_ev;
    end
    frame_pulse_in <= (pos == 0) ? high_pulse : ~high_pulse;
    send_in        <= tx_s[pos / 16][7 - (pos / 2) % 8];
    receive_in     <= tx_r[pos / 16][7 - (pos / 2) % 8];
  end

  // take each bit at its second clock; a released line shows the inverse
  always @(posedge serial_bit_clock_in) begin
    if (pos % 2 == 1) begin
      last_s = send_out_oe_n ? ~last_s : send_out;
      last_r = receive_out_oe_n ? ~last_r : receive_out;
      rx_s[pos / 16][7 - (pos / 2) % 8] = last_s;
      rx_r[pos / 16][7 - (pos / 2) % 8] = last_r;
    end
    pos = (pos + 1) % 512;
  end
endmodule : tdmps_framer_model

// File: tdmps_serial_port_tb.sv
// self-checking bench for the tdm pcm serial port
module tdmps_serial_port_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0, reset = 1'b1, run = 1'b0, high_pulse = 1'b0;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [12:0] wb_adr_i = 13'h0000;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h00000000, wb_dat_o;
  logic        wb_ack_o, serial_bit_clock_in, frame_pulse_in, send_in, receive_in;
  logic        output_drive_gate = 1'b1, freq_select = 1'b0;
  logic        send_out, send_out_oe_n, receive_out, receive_out_oe_n;
  int          mismatches = 0, checked = 0;

  // 125 MHz core clock
  always #4 clk = ~clk;

  tdmps_serial_port u_tdmps_serial_port (
    .clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .serial_bit_clock_in, .frame_pulse_in, .send_in, .receive_in,
    .output_drive_gate, .freq_select, .send_out, .send_out_oe_n, .receive_out,
    .receive_out_oe_n
  );

  tdmps_framer_model u_tdmps_framer_model (
    .run, .high_pulse, .serial_bit_clock_in, .frame_pulse_in, .send_in, .receive_in,
    .send_out, .send_out_oe_n, .receive_out, .receive_out_oe_n
  );

  // --------
  // helpers
  // --------
  task automatic wrap_up;
    if (mismatches == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask : chk1

  // one classic cycle; the request holds until ack is seen at an edge
  task automatic wb(input logic we, input logic [10:0] idx, input logic [7:0] wd,
                    input logic [3:0] sel, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= sel;
    wb_dat_i <= {24'h000000, wd};
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) mismatches++;
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task automatic wr(input logic [10:0] idx, input logic [7:0] wd, input logic [3:0] sel);
    logic [31:0] d;
    wb(1'b1, idx, wd, sel, d);
  endtask : wr

  // upper lanes must always read back as zero
  task automatic rd_chk(input logic [10:0] idx, input logic [7:0] exp);
    logic [31:0] d;
    wb(1'b0, idx, 8'h00, 4'hF, d);
    chk8(d[7:0], exp);
    chk1(|d[31:8], 1'b0);
  endtask : rd_chk

  // settle past the pulse so reads never straddle a frame boundary
  task automatic frames(input int k);
    repeat (k) @(u_tdmps_framer_model.frame_ev);
    repeat (40) @(posedge clk);
  endtask : frames

  task automatic chk_streams;
    foreach (u_tdmps_framer_model.got_s[i]) begin
      chk8(u_tdmps_framer_model.got_s[i], u_tdmps_framer_model.exp_s[i]);
      chk8(u_tdmps_framer_model.got_r[i], u_tdmps_framer_model.exp_r[i]);
    end
  endtask : chk_streams

  // --------
  // tests
  // --------
  initial begin
    logic [31:0] d0, d1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    rd_chk(11'h000, 8'h00);
    rd_chk(11'h001, 8'h08);
    chk1(send_out_oe_n, 1'b1);
    // byte lane, spare bits, an alias through bit 10 and an unmapped index
    wr(11'h000, 8'hA5, 4'hE);
    rd_chk(11'h000, 8'h00);
    wr(11'h000, 8'hBF, 4'h1);
    rd_chk(11'h000, 8'hBF);
    wr(11'h400, 8'h00, 4'hF);
    rd_chk(11'h000, 8'hBF);
    rd_chk(11'h400, 8'h00);
    rd_chk(11'h7FF, 8'h00);
    // every combination of gate pin and drive bit
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      output_drive_gate <= k[0];
      wr(11'h000, {1'b0, k[1], 6'h00}, 4'h1);
      repeat (8) @(posedge clk);
      chk1(send_out_oe_n, ~(k[0] & k[1]));
      chk1(receive_out_oe_n, ~(k[0] & k[1]));
      rd_chk(11'h001, {3'b000, k[0] & k[1], k[0], 3'b000});
    end
    // traffic with active-low pulses, then the other format mid-run
    run <= 1'b1;
    frames(4);
    rd_chk(11'h001, 8'h19);
    chk_streams;
    wb(1'b0, 11'h002, 8'h00, 4'hF, d0);
    frames(2);
    wb(1'b0, 11'h002, 8'h00, 4'hF, d1);
    chk8(d1[7:0] - d0[7:0], 8'h02);
    high_pulse <= 1'b1;
    frames(4);
    rd_chk(11'h001, 8'h1B);
    chk_streams;
    freq_select <= 1'b1;
    repeat (8) @(posedge clk);
    rd_chk(11'h001, 8'h1F);
    // a second reset while traffic runs
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    rd_chk(11'h000, 8'h00);
    chk1(send_out_oe_n, 1'b1);
    chk1(receive_out_oe_n, 1'b1);
    wrap_up;
  end

  // about ten frames of 4096 core cycles are needed; this leaves margin
  initial begin
    repeat (80000) @(posedge clk);
    mismatches++;
    wrap_up;
  end
endmodule : tdmps_serial_port_tb
